/* File: core/dio_cfg.svh */
// Purpose: Offsets, field positions and reset values of the digital I/O bank
// Assumes: Byte-wide I/O space accesses, offsets relative to the card base
// Notes: Definitions only
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH
// ==========================================================
// Register offsets
`define DIO_OFS_GLOBAL_EN 8'h00
`define DIO_OFS_AUX_DIR 8'h02
`define DIO_OFS_AUX_DATA 8'h03
`define DIO_OFS_IRQ_MASK 8'h05
`define DIO_OFS_AUX_STAT 8'h07
`define DIO_OFS_IRQ_POL 8'h2a
`define DIO_OFS_LANE0 8'hc0
`define DIO_OFS_LANE1 8'hc4
`define DIO_OFS_LANE2 8'hc8
`define DIO_OFS_CONFIG 8'hcc
`define DIO_OFS_WIDE_LO 8'hd0
`define DIO_OFS_WIDE_HI 8'hd4
// ==========================================================
// Fields and reset values
`define DIO_NIB_MASK 8'h0f
`define DIO_DIR_MASK 8'h07
`define DIO_RST_BYTE 8'h00
`define DIO_RST_NIB 4'h0
`define DIO_RST_DIR 3'h0
// Arbitrary neutral identity values
`define DIO_BOARD_ID 4'h5
`define DIO_AUX_IDENTITY_BITS 4'ha
`endif

/* File: core/dio_pkg.sv */
// Purpose: Shared types of the digital I/O bank
// Assumes: Constants live in dio_cfg.svh
// Notes: Types only
package dio_pkg;
    typedef logic [7:0] dio_byte_t;
    typedef logic [7:0] dio_addr_t;
    typedef logic [3:0] dio_nib_t;
endpackage

/* File: core/dio_bank.sv */
// Purpose: Register bank with three bidirectional lanes, aux lines, wide connectors
// Assumes: Host strobes are synchronous to clk; pins are asynchronous
// Notes: Read data registered one cycle after the read strobe
`timescale 1ns/100ps
`include "dio_cfg.svh"
module dio_bank
(
    input wire logic clk,
    input wire logic rst,
    input wire dio_pkg::dio_addr_t addr,
    input wire dio_pkg::dio_byte_t wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output dio_pkg::dio_byte_t rdData,
    input wire dio_pkg::dio_byte_t lane0In,
    input wire dio_pkg::dio_byte_t lane1In,
    input wire dio_pkg::dio_byte_t lane2In,
    output dio_pkg::dio_byte_t lane0Out,
    output dio_pkg::dio_byte_t lane1Out,
    output dio_pkg::dio_byte_t lane2Out,
    output logic [2:0] laneOe,
    input wire dio_pkg::dio_byte_t auxIn,
    output dio_pkg::dio_byte_t auxOut,
    output dio_pkg::dio_byte_t auxOe,
    input wire dio_pkg::dio_byte_t wideIn0,
    input wire dio_pkg::dio_byte_t wideIn1,
    output dio_pkg::dio_byte_t wideOut0,
    output dio_pkg::dio_byte_t wideOut1,
    output logic irqReq
);
    import dio_pkg::*;

    // ==========================================================
    // Pin synchronisers
    dio_byte_t l0S2_r, l1S2_r, l2S2_r, axS2_r, w0S2_r, w1S2_r;

    dio_sync2 #(.W(8)) syncLane0
    (
        .clk(clk),
        .pinIn(lane0In),
        .pinSync(l0S2_r)
    );

    dio_sync2 #(.W(8)) syncLane1
    (
        .clk(clk),
        .pinIn(lane1In),
        .pinSync(l1S2_r)
    );

    dio_sync2 #(.W(8)) syncLane2
    (
        .clk(clk),
        .pinIn(lane2In),
        .pinSync(l2S2_r)
    );

    dio_sync2 #(.W(8)) syncAux
    (
        .clk(clk),
        .pinIn(auxIn),
        .pinSync(axS2_r)
    );

    dio_sync2 #(.W(8)) syncWide0
    (
        .clk(clk),
        .pinIn(wideIn0),
        .pinSync(w0S2_r)
    );

    dio_sync2 #(.W(8)) syncWide1
    (
        .clk(clk),
        .pinIn(wideIn1),
        .pinSync(w1S2_r)
    );

    // ==========================================================
    // Address decode
    wire wEn = wrStb && addr == `DIO_OFS_GLOBAL_EN;
    wire wAuxDir = wrStb && addr == `DIO_OFS_AUX_DIR;
    wire wAuxDat = wrStb && addr == `DIO_OFS_AUX_DATA;
    wire wMask = wrStb && addr == `DIO_OFS_IRQ_MASK;
    wire wPol = wrStb && addr == `DIO_OFS_IRQ_POL;
    wire wL0 = wrStb && addr == `DIO_OFS_LANE0;
    wire wL1 = wrStb && addr == `DIO_OFS_LANE1;
    wire wL2 = wrStb && addr == `DIO_OFS_LANE2;
    wire wCfg = wrStb && addr == `DIO_OFS_CONFIG;
    wire wWlo = wrStb && addr == `DIO_OFS_WIDE_LO;
    wire wWhi = wrStb && addr == `DIO_OFS_WIDE_HI;

    // ==========================================================
    // Control registers
    logic ioEn_r;
    dio_byte_t auxDir_r, auxDat_r, l0_r, l1_r, l2_r, wlo_r, whi_r;
    dio_nib_t mask_r, pol_r;
    logic [2:0] dir_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ioEn_r <= 1'b0;
            auxDir_r <= `DIO_RST_BYTE;
            dir_r <= `DIO_RST_DIR;
        end
        else
        begin
            if (wEn)
                ioEn_r <= wrData[0];
            if (wAuxDir)
                auxDir_r <= wrData;
            if (wCfg)
                dir_r <= wrData[2:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            auxDat_r <= `DIO_RST_BYTE;
            mask_r <= `DIO_RST_NIB;
            pol_r <= `DIO_RST_NIB;
        end
        else
        begin
            if (wAuxDat)
                auxDat_r <= wrData;
            if (wMask)
                mask_r <= wrData[3:0];
            if (wPol)
                pol_r <= wrData[3:0];
        end
    end

    // Lane, wide writes ignored while I/O disabled
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            l0_r <= `DIO_RST_BYTE;
            l1_r <= `DIO_RST_BYTE;
            l2_r <= `DIO_RST_BYTE;
        end
        else
        begin
            if (wL0 && ioEn_r)
                l0_r <= wrData;
            if (wL1 && ioEn_r)
                l1_r <= wrData;
            if (wL2 && ioEn_r)
                l2_r <= wrData;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wlo_r <= `DIO_RST_BYTE;
            whi_r <= `DIO_RST_BYTE;
        end
        else
        begin
            if (wWlo && ioEn_r)
                wlo_r <= wrData;
            if (wWhi && ioEn_r)
                whi_r <= wrData;
        end
    end

    // ==========================================================
    // Read mux and interrupt
    wire dio_nib_t srcLvl = axS2_r[3:0];
    wire dio_nib_t srcAct = ~(srcLvl ^ pol_r) & mask_r;
    wire dio_byte_t gate = ioEn_r ? 8'hff : 8'h00;
    wire dio_byte_t cfgRd = {1'b0, `DIO_BOARD_ID, dir_r};
    wire dio_byte_t statRd = {`DIO_AUX_IDENTITY_BITS, srcLvl};
    wire dio_byte_t rdNxt =
        addr == `DIO_OFS_AUX_DATA ? auxDat_r :
        addr == `DIO_OFS_AUX_STAT ? statRd :
        addr == `DIO_OFS_CONFIG ? cfgRd :
        addr == `DIO_OFS_LANE0 ? (l0S2_r & gate) :
        addr == `DIO_OFS_LANE1 ? (l1S2_r & gate) :
        addr == `DIO_OFS_LANE2 ? (l2S2_r & gate) :
        addr == `DIO_OFS_WIDE_LO ? (w0S2_r & gate) :
        addr == `DIO_OFS_WIDE_HI ? (w1S2_r & gate) : 8'h00;
    wire irqNxt = ioEn_r && (|srcAct);
    wire [2:0] oeNxt = ioEn_r ? dir_r : 3'h0;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdData <= 8'h00;
            irqReq <= 1'b0;
            laneOe <= 3'h0;
            lane0Out <= 8'h00;
            lane1Out <= 8'h00;
            lane2Out <= 8'h00;
            auxOut <= 8'h00;
            auxOe <= 8'h00;
            wideOut0 <= 8'h00;
            wideOut1 <= 8'h00;
        end
        else
        begin
            rdData <= rdStb ? rdNxt : 8'h00;
            irqReq <= irqNxt;
            laneOe <= oeNxt;
            lane0Out <= l0_r;
            lane1Out <= l1_r;
            lane2Out <= l2_r;
            auxOut <= auxDat_r & auxDir_r;
            auxOe <= auxDir_r & gate;
            wideOut0 <= wlo_r & gate;
            wideOut1 <= whi_r & gate;
        end
    end

    // ==========================================================
    // Checks
    en_gates_oe_a: assert property (@(posedge clk) disable iff (rst)
        !ioEn_r |=> laneOe == 3'h0 && auxOe == 8'h00)
        else $error("outputs enabled while I/O disabled");
    dir_write_a: assert property (@(posedge clk) disable iff (rst)
        wCfg && ioEn_r |=> ##1 laneOe == $past(wrData[2:0], 2))
        else $error("lane direction not taken");
    aux_dir_a: assert property (@(posedge clk) disable iff (rst)
        wAuxDir && ioEn_r |=> ##1 auxOe == $past(wrData, 2))
        else $error("aux direction not taken");
    irq_cause_a: assert property (@(posedge clk) disable iff (rst)
        irqReq |-> $past(ioEn_r) && $past(srcAct) != 4'h0)
        else $error("interrupt without enabled source");
    mask_block_a: assert property (@(posedge clk) disable iff (rst)
        mask_r == 4'h0 |=> !irqReq)
        else $error("interrupt with all sources masked");
    cfg_read_a: assert property (@(posedge clk) disable iff (rst)
        rdStb && addr == `DIO_OFS_CONFIG |=> rdData[7] == 1'b0 && rdData[2:0] == $past(dir_r))
        else $error("config read wrong");
    stat_read_a: assert property (@(posedge clk) disable iff (rst)
        rdStb && addr == `DIO_OFS_AUX_STAT |=> rdData[3:0] == $past(axS2_r[3:0]))
        else $error("status read wrong");
    lane_read_a: assert property (@(posedge clk) disable iff (rst)
        rdStb && addr == `DIO_OFS_LANE1 && ioEn_r |=> rdData == $past(l1S2_r))
        else $error("lane read wrong");
    wide_write_a: assert property (@(posedge clk) disable iff (rst)
        wWhi && ioEn_r |=> ##1 wideOut1 == $past(wrData, 2) || !ioEn_r)
        else $error("wide write lost");
    aux_out_a: assert property (@(posedge clk) disable iff (rst)
        auxOut == ($past(auxDat_r) & $past(auxDir_r)))
        else $error("aux output level wrong");
    rst_dir_a: assert property (@(posedge clk)
        rst |=> dir_r == 3'h0 && auxDir_r == 8'h00 && !ioEn_r)
        else $error("reset directions wrong");
    pol_a: assert property (@(posedge clk) disable iff (rst)
        mask_r[0] && ioEn_r && (srcLvl[0] == pol_r[0]) |=> irqReq)
        else $error("polarity source missed");
    // Two-edge checks allow for the registered output stage
    en_write_a: assert property (@(posedge clk) disable iff (rst)
        wEn |=> ioEn_r == $past(wrData[0]))
        else $error("global enable not taken");
    rst_out_a: assert property (@(posedge clk)
        rst |=> laneOe == 3'h0 && !irqReq && rdData == 8'h00)
        else $error("outputs not cleared by reset");
    rst_aux_a: assert property (@(posedge clk)
        rst |=> auxOe == 8'h00 && auxOut == 8'h00)
        else $error("aux lines not inputs after reset");
    mask_write_a: assert property (@(posedge clk) disable iff (rst)
        wMask |=> mask_r == $past(wrData[3:0]))
        else $error("mask write not taken");
    pol_write_a: assert property (@(posedge clk) disable iff (rst)
        wPol |=> pol_r == $past(wrData[3:0]))
        else $error("polarity write not taken");
    aux_dat_wr_a: assert property (@(posedge clk) disable iff (rst)
        wAuxDat |=> auxDat_r == $past(wrData))
        else $error("aux data write not taken");
    lane_gate_a: assert property (@(posedge clk) disable iff (rst)
        wL0 && !ioEn_r |=> l0_r == $past(l0_r))
        else $error("lane write taken while disabled");
    wide_gate_a: assert property (@(posedge clk) disable iff (rst)
        wWlo && !ioEn_r |=> wlo_r == $past(wlo_r))
        else $error("wide write taken while disabled");
    read_gate_a: assert property (@(posedge clk) disable iff (rst)
        rdStb && addr == `DIO_OFS_LANE2 && !ioEn_r |=> rdData == 8'h00)
        else $error("lane read while disabled not zero");
    lane0_write_a: assert property (@(posedge clk) disable iff (rst)
        wL0 && ioEn_r |=> ##1 lane0Out == $past(wrData, 2))
        else $error("first lane write lost");
    lane2_write_a: assert property (@(posedge clk) disable iff (rst)
        wL2 && ioEn_r |=> ##1 lane2Out == $past(wrData, 2))
        else $error("third lane write lost");
    lane0_read_a: assert property (@(posedge clk) disable iff (rst)
        rdStb && addr == `DIO_OFS_LANE0 && ioEn_r |=> rdData == $past(l0S2_r))
        else $error("first lane read wrong");
    wide_lo_read_a: assert property (@(posedge clk) disable iff (rst)
        rdStb && addr == `DIO_OFS_WIDE_LO && ioEn_r |=> rdData == $past(w0S2_r))
        else $error("wide low read wrong");
    wide_lo_write_a: assert property (@(posedge clk) disable iff (rst)
        wWlo && ioEn_r |=> ##1 wideOut0 == $past(wrData, 2))
        else $error("wide low write lost");
    aux_read_a: assert property (@(posedge clk) disable iff (rst)
        rdStb && addr == `DIO_OFS_AUX_DATA |=> rdData == $past(auxDat_r))
        else $error("aux data read wrong");
    stat_id_a: assert property (@(posedge clk) disable iff (rst)
        rdStb && addr == `DIO_OFS_AUX_STAT |=> rdData[7:4] == `DIO_AUX_IDENTITY_BITS)
        else $error("aux identity bits wrong");
    board_id_a: assert property (@(posedge clk) disable iff (rst)
        rdStb && addr == `DIO_OFS_CONFIG |=> rdData[6:3] == `DIO_BOARD_ID)
        else $error("board identifier wrong");
    irq_any_a: assert property (@(posedge clk) disable iff (rst)
        ioEn_r && srcAct != 4'h0 |=> irqReq)
        else $error("active source raised no interrupt");
    irq_off_a: assert property (@(posedge clk) disable iff (rst)
        !ioEn_r |=> !irqReq)
        else $error("interrupt while I/O disabled");
endmodule

// ==========================================================
// Two-flop synchroniser for one pin group
module dio_sync2
#(
    parameter int W = 8
)
(
    input wire logic clk,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinSync
);
    // First stage read by nothing but the second
    logic [W-1:0] meta_r;

    always_ff @(posedge clk)
    begin
        meta_r <= pinIn;
        pinSync <= meta_r;
    end
endmodule

/* File: dv/dio_host.sv */
// Purpose: Host side model issuing byte writes and reads to the bank
// Assumes: Requests launched 1 ns after the rising edge
// Notes: Released lines turn inverted so stale values never look valid
`timescale 1ns/100ps
module dio_host
(
    input wire logic clk,
    output dio_pkg::dio_addr_t addr,
    output dio_pkg::dio_byte_t wrData,
    output logic wrStb,
    output logic rdStb,
    input wire dio_pkg::dio_byte_t rdData
);
    import dio_pkg::*;
    initial {addr, wrData, wrStb, rdStb} = '0;
    task automatic wr(input dio_addr_t a, input dio_byte_t d);
        @(posedge clk) #1;
        {addr, wrData, wrStb} = {a, d, 1'b1};
        @(posedge clk) #1;
        {addr, wrData, wrStb} = {~a, ~d, 1'b0};
    endtask
    task automatic rd(input dio_addr_t a, output dio_byte_t d);
        @(posedge clk) #1;
        {addr, rdStb} = {a, 1'b1};
        @(posedge clk) #1;
        {addr, rdStb} = {~a, 1'b0};
        d = rdData;
    endtask
endmodule

/* File: dv/dio_bank_test.sv */
// Purpose: Self-checking bench of the digital I/O register bank
// Assumes: Host model drives the register strobes
// Notes: Waits of 4 edges cover write and pin synchroniser latency
`timescale 1ns/100ps
`include "dio_cfg.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module dio_bank_test;
    import dio_pkg::*;
    logic clk = 0;
    logic rst = 1;
    int n_errors = 0;
    int comparisons = 0;
    dio_addr_t addr;
    dio_byte_t wrData, rdData, lane0Out, lane1Out, lane2Out, auxOut, auxOe;
    dio_byte_t wideOut0, wideOut1;
    dio_byte_t auxIn = 8'h00;
    logic wrStb, rdStb, irqReq;
    logic [2:0] laneOe;
    always #12.5 clk = ~clk;
    dio_host host (.clk(clk), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData));
    dio_bank dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
        .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .lane0In(8'h69),
        .lane1In(8'h96), .lane2In(8'h0f), .lane0Out(lane0Out),
        .lane1Out(lane1Out), .lane2Out(lane2Out), .laneOe(laneOe),
        .auxIn(auxIn), .auxOut(auxOut), .auxOe(auxOe), .wideIn0(8'hc3),
        .wideIn1(8'h3c), .wideOut0(wideOut0), .wideOut1(wideOut1),
        .irqReq(irqReq));
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic t_lanes();
        dio_byte_t d;
        `CHK({laneOe, auxOe, irqReq}, 12'h0)
        host.rd(`DIO_OFS_CONFIG, d);
        `CHK(d, {1'b0, `DIO_BOARD_ID, 3'h0})
        // Writes while disabled must vanish, not linger until enable
        host.wr(`DIO_OFS_LANE0, 8'h5a);
        host.rd(8'h01, d);
        `CHK(d, 8'h00)
        host.rd(`DIO_OFS_LANE2, d);
        `CHK(d, 8'h00)
        host.wr(`DIO_OFS_GLOBAL_EN, 8'h01);
        host.wr(`DIO_OFS_CONFIG, 8'h07);
        settle();
        `CHK({laneOe, lane0Out}, 11'h700)
        host.wr(`DIO_OFS_LANE0, 8'h11);
        host.wr(`DIO_OFS_LANE1, 8'h22);
        host.wr(`DIO_OFS_LANE2, 8'h33);
        settle();
        `CHK({lane0Out, lane1Out, lane2Out}, 24'h112233)
        host.wr(`DIO_OFS_CONFIG, 8'h04);
        settle();
        `CHK(laneOe, 3'h4)
        host.rd(`DIO_OFS_CONFIG, d);
        `CHK(d, {1'b0, `DIO_BOARD_ID, 3'h4})
        host.rd(`DIO_OFS_LANE1, d);
        `CHK(d, 8'h96)
        host.rd(`DIO_OFS_LANE0, d);
        `CHK(d, 8'h69)
    endtask
    task automatic t_wide_aux();
        dio_byte_t d;
        host.wr(`DIO_OFS_WIDE_LO, 8'ha5);
        host.wr(`DIO_OFS_WIDE_HI, 8'h5a);
        host.wr(`DIO_OFS_AUX_DIR, 8'hf0);
        host.wr(`DIO_OFS_AUX_DATA, 8'haa);
        settle();
        `CHK({wideOut1, wideOut0}, 16'h5aa5)
        `CHK({auxOe, auxOut}, 16'hf0a0)
        host.rd(`DIO_OFS_WIDE_LO, d);
        `CHK(d, 8'hc3)
        host.rd(`DIO_OFS_WIDE_HI, d);
        `CHK(d, 8'h3c)
        host.rd(`DIO_OFS_AUX_DATA, d);
        `CHK(d, 8'haa)
    endtask
    task automatic t_irq();
        dio_byte_t d;
        host.wr(`DIO_OFS_IRQ_POL, 8'h0f);
        host.wr(`DIO_OFS_IRQ_MASK, 8'h02);
        auxIn = 8'h01;
        settle();
        `CHK(irqReq, 1'b0)
        host.wr(`DIO_OFS_IRQ_MASK, 8'h01);
        settle();
        `CHK(irqReq, 1'b1)
        host.rd(`DIO_OFS_AUX_STAT, d);
        `CHK(d, {`DIO_AUX_IDENTITY_BITS, 4'h1})
        host.wr(`DIO_OFS_IRQ_POL, 8'h0e);
        settle();
        `CHK(irqReq, 1'b0)
        auxIn = 8'h00;
        settle();
        `CHK(irqReq, 1'b1)
        host.wr(`DIO_OFS_GLOBAL_EN, 8'h00);
        host.wr(`DIO_OFS_WIDE_LO, 8'hff);
        settle();
        `CHK({irqReq, laneOe, auxOe, wideOut0}, 20'h0)
    endtask
    task automatic results();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_errors++;
        results();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        #1 rst = 0;
        t_lanes();
        t_wide_aux();
        t_irq();
        results();
    end
endmodule
